/* File: dv/cfgrb_asserts.sv */
// Concurrent checks on the ports of the configuration register bank
`default_nettype none
module cfgrb_asserts #(
   parameter [7:0] DEVICE_IDENTIFICATION = 8'h5a
) (
   // Clock and resets
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       vcc_por_n,
   input wire logic       stby_por_n,
   // Host port
   input wire logic       cfg_mode,
   input wire logic       host_wr,
   input wire logic       host_rd,
   input wire logic       host_port,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   // Pin and controls
   input wire logic       printer_ack_in,
   input wire logic       soft_reset_out,
   input wire logic [7:0] power_control_out,
   input wire logic [7:0] power_mgmt_out,
   input wire logic [5:0] activate_out,
   input wire logic       parallel_irq_out
);
   timeunit 1ns;
   timeprecision 1ns;

   wire        any_rst = !rst_n || !vcc_por_n || !stby_por_n;
   wire        take_wr = cfg_mode && host_wr;
   wire        take_rd = cfg_mode && host_rd && !host_wr;
   logic [7:0] idx;

   // Mirror of the index port, so data cycles can be decoded here
   always @(posedge sys_clk)
      if (any_rst)
         idx <= 8'h00;
      else if (take_wr && !host_port)
         idx <= host_wdata;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (any_rst);

   a_soft_pulse: assert property (
      take_wr && host_port && idx == 8'h02 && host_wdata[0] |=> soft_reset_out)
      else $error("soft reset pulse missing");
   a_soft_once: assert property (soft_reset_out |=> !soft_reset_out)
      else $error("soft reset pulse too long");
   a_soft_clear: assert property (
      soft_reset_out |=> power_control_out == 8'h00 && activate_out == 6'h00)
      else $error("soft reset left power or activate set");
   a_mgmt_keep: assert property (
      soft_reset_out && !host_wr |=> $stable(power_mgmt_out))
      else $error("power management lost on soft reset");
   a_pwr_bits: assert property (
      take_wr && host_port && idx == 8'h22 |=> power_control_out == ($past(host_wdata) & 8'h39))
      else $error("power control bits wrong");
   a_mgmt_bits: assert property (
      take_wr && host_port && idx == 8'h23 |=> power_mgmt_out == ($past(host_wdata) & 8'h39))
      else $error("power management bits wrong");
   a_idle_hold: assert property (
      !cfg_mode && !soft_reset_out |=> $stable(power_control_out) && $stable(power_mgmt_out))
      else $error("register changed outside configuration mode");
   a_rdata_hold: assert property (!(cfg_mode && host_rd) |=> $stable(host_rdata))
      else $error("read data changed without a read");
   a_id_read: assert property (
      take_rd && host_port && idx == 8'h20 |=> host_rdata == DEVICE_IDENTIFICATION)
      else $error("identification read wrong");
   a_pirq_idle: assert property (
      !activate_out[1] && !$past(activate_out[1]) |-> parallel_irq_out)
      else $error("parallel interrupt low while inactive");
   a_pirq_follow: assert property (
      activate_out[1] [*4] |-> parallel_irq_out == $past(printer_ack_in, 3))
      else $error("parallel interrupt not following acknowledge");
endmodule // cfgrb_asserts

bind cfgrb_top cfgrb_asserts #(.DEVICE_IDENTIFICATION(DEVICE_IDENTIFICATION)) u_asserts (
   .sys_clk(sys_clk), .rst_n(rst_n), .vcc_por_n(vcc_por_n), .stby_por_n(stby_por_n),
   .cfg_mode(cfg_mode), .host_wr(host_wr), .host_rd(host_rd), .host_port(host_port),
   .host_wdata(host_wdata), .host_rdata(host_rdata), .printer_ack_in(printer_ack_in),
   .soft_reset_out(soft_reset_out), .power_control_out(power_control_out),
   .power_mgmt_out(power_mgmt_out), .activate_out(activate_out),
   .parallel_irq_out(parallel_irq_out));
`default_nettype wire

/* File: dv/cfgrb_host.sv */
// Host model issuing index and data port cycles to the register bank
`default_nettype none
module cfgrb_host (
   // Clock
   input  wire logic       sys_clk,
   // Port cycles
   output var  logic       cfg_mode,
   output var  logic       host_wr,
   output var  logic       host_rd,
   output var  logic       host_port,
   output var  logic [7:0] host_wdata,
   // Read return
   input  wire logic [7:0] host_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      cfg_mode   = 1'b1;
      host_wr    = 1'b0;
      host_rd    = 1'b0;
      host_port  = 1'b0;
      host_wdata = 8'h00;
   end

   // Mode changes only on a falling edge, never inside a cycle
   task automatic mode(input logic m);
      @(negedge sys_clk);
      cfg_mode = m;
   endtask

   // One strobed cycle; read data is taken a half cycle after the taking edge
   task automatic cyc(input logic w, input logic p, input logic [7:0] d, output logic [7:0] q);
      @(negedge sys_clk);
      host_wr    = w;
      host_rd    = !w;
      host_port  = p;
      host_wdata = d;
      @(negedge sys_clk);
      q          = host_rdata;
      host_wr    = 1'b0;
      host_rd    = 1'b0;
      host_wdata = ~d; // Released bus must not look like live data
   endtask

   // Index port first, then the data port
   task automatic acc(input logic w, input logic [7:0] ix, input logic [7:0] d,
                      output logic [7:0] q);
      cyc(1'b1, 1'b0, ix, q);
      cyc(w, 1'b1, d, q);
   endtask
endmodule // cfgrb_host
`default_nettype wire

/* File: dv/cfgrb_tb.sv */
// Self-checking bench for the configuration register bank
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); n_fail++; end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   logic       sys_clk, rst_n, vcc_por_n, stby_por_n, cfg_mode, host_wr, host_rd, host_port;
   logic [7:0] host_wdata, host_rdata, floppy_rate_data, serial1_fcr_data, serial2_fcr_data;
   logic [7:0] smi_event_1, smi_event_2, pme_event, wake_event, power_control_out;
   logic [7:0] power_mgmt_out, q;
   logic [5:0] activate_out;
   logic [1:0] wdt_state;
   logic       floppy_rate_wr, serial1_fcr_wr, serial2_fcr_wr, printer_ack_in;
   logic       soft_reset_out, wdt_force_out, parallel_irq_out;
   int         n_fail, n_checks;
   logic [7:0] rsv [8] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h08, 8'h1f, 8'h25, 8'h2a};
   logic [7:0] ldns [6] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08};

   cfgrb_top dut (.sys_clk, .rst_n, .vcc_por_n, .stby_por_n, .cfg_mode, .host_wr, .host_rd,
      .host_port, .host_wdata, .host_rdata, .floppy_rate_wr, .floppy_rate_data,
      .serial1_fcr_wr, .serial1_fcr_data, .serial2_fcr_wr, .serial2_fcr_data, .smi_event_1,
      .smi_event_2, .pme_event, .wake_event, .wdt_state, .printer_ack_in, .soft_reset_out,
      .power_control_out, .power_mgmt_out, .activate_out, .wdt_force_out, .parallel_irq_out);
   cfgrb_host host (.sys_clk, .cfg_mode, .host_wr, .host_rd, .host_port, .host_wdata,
      .host_rdata);

   always #10 sys_clk = ~sys_clk;

   task automatic complete_run;
      if (n_fail == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] ix, input logic [7:0] d);
      host.acc(1'b1, ix, d, q);
   endtask

   task automatic reg_rd(input logic [7:0] ix, input logic [7:0] e);
      host.acc(1'b0, ix, 8'h00, q);
      `CHK(q, e)
   endtask

   // Asserts the resets in m = {standby, main, hard} for two cycles
   task automatic hit(input logic [2:0] m);
      @(negedge sys_clk);
      {stby_por_n, vcc_por_n, rst_n} = ~m;
      repeat (2) @(negedge sys_clk);
      {stby_por_n, vcc_por_n, rst_n} = 3'b111;
   endtask

   // Hang guard: the sequence needs well under a thousand cycles
   initial
   begin
      #100000;
      n_fail++;
      complete_run();
   end

   initial
   begin
      sys_clk = 1'b0;
      {stby_por_n, vcc_por_n, rst_n} = 3'b000;
      {floppy_rate_wr, serial1_fcr_wr, serial2_fcr_wr, printer_ack_in} = 4'h0;
      {floppy_rate_data, serial1_fcr_data, serial2_fcr_data} = 24'h000000;
      {smi_event_1, smi_event_2, pme_event, wake_event} = 32'h00000000;
      wdt_state = 2'b10;
      n_fail = 0;
      n_checks = 0;
      repeat (2) @(negedge sys_clk);
      {stby_por_n, vcc_por_n, rst_n} = 3'b111;
      reg_rd(8'h03, 8'h03);
      reg_wr(8'h20, 8'hff);
      reg_rd(8'h20, 8'h5a);
      reg_wr(8'h21, 8'hff);
      reg_rd(8'h21, 8'h01);
      foreach (rsv[i])
      begin
         reg_wr(rsv[i], 8'hff);
         reg_rd(rsv[i], 8'h00);
      end
      reg_wr(8'h22, 8'hff);
      `CHK(power_control_out, 8'h39)
      reg_rd(8'ha2, 8'h00);
      reg_wr(8'h23, 8'hff);
      reg_rd(8'h23, 8'h39);
      host.mode(1'b0);
      reg_wr(8'h22, 8'h00);
      host.mode(1'b1);
      reg_rd(8'h22, 8'h39);
      `CHK(parallel_irq_out, 1'b1)
      for (int i = 0; i < 6; i++)
      begin
         reg_wr(8'h07, ldns[i]);
         reg_wr(8'h30, 8'h01);
         `CHK(activate_out, 6'((1 << (i + 1)) - 1))
      end
      reg_wr(8'h07, 8'h01);
      reg_wr(8'h30, 8'h01);
      reg_rd(8'h30, 8'h00);
      reg_wr(8'h07, 8'h03);
      reg_rd(8'h30, 8'h01);
      `CHK(parallel_irq_out, 1'b0)
      printer_ack_in = 1'b1;
      repeat (4) @(negedge sys_clk);
      `CHK(parallel_irq_out, 1'b1)
      reg_wr(8'h02, 8'h01);
      `CHK(soft_reset_out, 1'b1)
      reg_rd(8'h02, 8'h00);
      `CHK(activate_out, 6'h00)
      reg_rd(8'h22, 8'h00);
      reg_rd(8'h23, 8'h39);
      reg_rd(8'h07, 8'h03);
      reg_wr(8'h07, 8'h08);
      reg_wr(8'hb5, 8'ha5);
      reg_wr(8'hc5, 8'h3c);
      reg_wr(8'hc8, 8'hc3);
      // Shadow loads and event pulses, one cycle wide
      @(negedge sys_clk);
      {floppy_rate_wr, serial1_fcr_wr, serial2_fcr_wr} = 3'b111;
      {floppy_rate_data, serial1_fcr_data, serial2_fcr_data} = 24'h123456;
      {pme_event, smi_event_1, smi_event_2, wake_event} = 32'h81104002;
      @(negedge sys_clk);
      {floppy_rate_wr, serial1_fcr_wr, serial2_fcr_wr} = 3'b000;
      {pme_event, smi_event_1, smi_event_2, wake_event} = 32'h00000000;
      reg_wr(8'hf4, 8'h03);
      `CHK(wdt_force_out, 1'b1)
      reg_rd(8'hf4, 8'h09);
      reg_rd(8'hc2, 8'h12);
      reg_rd(8'hc3, 8'h34);
      reg_rd(8'hc4, 8'h56);
      reg_rd(8'hb6, 8'h10);
      reg_rd(8'hb7, 8'h40);
      reg_rd(8'hc7, 8'h02);
      reg_wr(8'hc6, 8'h01);
      reg_rd(8'hc6, 8'h80);
      hit(3'b001);
      reg_rd(8'h23, 8'h00);
      reg_wr(8'h07, 8'h08);
      reg_rd(8'hb5, 8'ha5);
      reg_rd(8'hc5, 8'h3c);
      reg_rd(8'hf4, 8'h09);
      reg_rd(8'hc2, 8'h12);
      hit(3'b010);
      reg_wr(8'h07, 8'h08);
      reg_rd(8'hb5, 8'h00);
      reg_rd(8'hc8, 8'hc3);
      reg_rd(8'hf4, 8'h08);
      reg_rd(8'hc6, 8'h80);
      hit(3'b100);
      reg_wr(8'h07, 8'h08);
      reg_rd(8'hc8, 8'h00);
      reg_rd(8'hc6, 8'h00);
      reg_rd(8'hc2, 8'h00);
      complete_run();
   end
endmodule // testbench
`default_nettype wire

/* File: hdl/cfgrb_act_bank.v */
// Activate bits of the six logical devices, one per bank
`default_nettype none
`include "cfgrb_regs.vh"

module cfgrb_act_bank (
   // Clock
   input  wire       sys_clk,
   // Clear from any reset, soft reset included
   input  wire       clr,
   // Write strobe for the activate index
   input  wire       wr,
   input  wire [7:0] ldn,
   input  wire       wbit,
   // Activate bits
   output wire [5:0] act
);

   // Device number of each bank, entry 0 lowest
   localparam [47:0] LDN_TAB = {`CFGRB_LDN_AUX, `CFGRB_LDN_KBD,
                                `CFGRB_LDN_SER2, `CFGRB_LDN_SER1,
                                `CFGRB_LDN_PAR, `CFGRB_LDN_FLOPPY};

   reg [5:0] act_q;

   genvar i;
   generate
      for (i = 0; i < `CFGRB_NUM_LD; i = i + 1)
      begin : g_bank
         // Only the bank selected by the full device number changes
         always @(posedge sys_clk)
         begin
            if (clr)
               act_q[i] <= 1'b0; // R05
            else if (wr && (ldn == LDN_TAB[i*8 +: 8])) // R07
               act_q[i] <= wbit;
         end
      end
   endgenerate

   assign act = act_q;

endmodule // cfgrb_act_bank
`default_nettype wire

/* File: hdl/cfgrb_regs.vh */
// Index map, reset values and field layout of the configuration register bank
`ifndef CFGRB_REGS_VH
`define CFGRB_REGS_VH

// Global register indices
`define CFGRB_IX_CFGCTL  8'h02
`define CFGRB_IX_IDXADR  8'h03
`define CFGRB_IX_LDN     8'h07
`define CFGRB_IX_DEVID   8'h20
`define CFGRB_IX_DEVREV  8'h21
`define CFGRB_IX_PWRCTL  8'h22
`define CFGRB_IX_PWRMGT  8'h23
`define CFGRB_IX_LDBASE  8'h30

// Logical device indices
`define CFGRB_IX_ACT     8'h30
`define CFGRB_IX_SMIEN2  8'hb5
`define CFGRB_IX_SMIST1  8'hb6
`define CFGRB_IX_SMIST2  8'hb7
`define CFGRB_IX_PINMUX  8'hc0
`define CFGRB_IX_FDCHG   8'hc1
`define CFGRB_IX_FRATE   8'hc2
`define CFGRB_IX_S1FCR   8'hc3
`define CFGRB_IX_S2FCR   8'hc4
`define CFGRB_IX_PMECTL  8'hc5
`define CFGRB_IX_PMEST   8'hc6
`define CFGRB_IX_PMEWST  8'hc7
`define CFGRB_IX_PMEWEN  8'hc8
`define CFGRB_IX_WDTO    8'hf1
`define CFGRB_IX_WDVAL   8'hf2
`define CFGRB_IX_WDSET   8'hf3
`define CFGRB_IX_WDCTL   8'hf4

// Reset values
`define CFGRB_RST_ZERO   8'h00
`define CFGRB_RST_IDXADR 8'h03
`define CFGRB_RST_PINMUX 8'h02
`define CFGRB_RST_FDCHG  8'h01

// Field layout
`define CFGRB_SOFT_BIT   0
`define CFGRB_ACT_BIT    0
`define CFGRB_PWR_MASK   8'h39
`define CFGRB_PWR_FLOPPY 0
`define CFGRB_PWR_PAR    3
`define CFGRB_PWR_SER1   4
`define CFGRB_PWR_SER2   5
`define CFGRB_WDC_RW     8'h01
`define CFGRB_WDC_FORCE  1
`define CFGRB_WDC_RO_LO  2

// Logical device numbers
`define CFGRB_LDN_FLOPPY 8'h00
`define CFGRB_LDN_PAR    8'h03
`define CFGRB_LDN_SER1   8'h04
`define CFGRB_LDN_SER2   8'h05
`define CFGRB_LDN_KBD    8'h07
`define CFGRB_LDN_AUX    8'h08
`define CFGRB_NUM_LD     6
`define CFGRB_ACT_PAR    1

`endif

/* File: hdl/cfgrb_top.v */
// Configuration register bank: index/data port, global and aux device registers
//
// How it works
// R01: Unimplemented registers and bits read zero
// R02: Index decoded on all eight bits
// R03: Index then data port, config mode only
// R04: Soft reset bit self-clears after write
// R05: Soft reset loads only listed registers
// R06: Device number selects visible register bank
// R07: Activate acts on selected device only
// R08: Identification register is fixed, read-only
// R09: Revision register is fixed, read-only
// R10: Power control bits per function
// R11: Power control cleared by every reset
// R12: Power management bits, six and seven zero
// R13: Power management survives soft reset
// R14: Watchdog control bit 0 survives hard reset
// R15: Watchdog control mixes read and write bits
// R16: Parallel interrupt high until port activated
// R17: SMI registers cleared only by power-on
// R18: PME status clearable, standby power-on reset
// R19: PME enables reset on standby power-on only
// R20: Shadows read back write-only FIFO, rate values
// R21: Six logical devices, each banked
// R22: Config control reads back zero
`default_nettype none
`include "cfgrb_regs.vh"

module cfgrb_top #(
   parameter [7:0] DEVICE_IDENTIFICATION  = 8'h5a, // Arbitrary value
   parameter [7:0] DEVICE_REV = 8'h01  // Arbitrary value
) (
   // Clock and resets, all synchronous, active low
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       vcc_por_n,
   input  wire       stby_por_n,
   // Host access
   input  wire       cfg_mode,
   input  wire       host_wr,
   input  wire       host_rd,
   input  wire       host_port,
   input  wire [7:0] host_wdata,
   output reg  [7:0] host_rdata,
   // Write-only values seen by the functions
   input  wire       floppy_rate_wr,
   input  wire [7:0] floppy_rate_data,
   input  wire       serial1_fcr_wr,
   input  wire [7:0] serial1_fcr_data,
   input  wire       serial2_fcr_wr,
   input  wire [7:0] serial2_fcr_data,
   // Event set pulses and watchdog state
   input  wire [7:0] smi_event_1,
   input  wire [7:0] smi_event_2,
   input  wire [7:0] pme_event,
   input  wire [7:0] wake_event,
   input  wire [1:0] wdt_state,
   // Printer acknowledge pin
   input  wire       printer_ack_in,
   // Controls to the functions
   output reg        soft_reset_out,
   output reg  [7:0] power_control_out,
   output reg  [7:0] power_mgmt_out,
   output wire [5:0] activate_out,
   output reg        wdt_force_out,
   output reg        parallel_irq_out
);

   // Reset terms
   wire stby_por = ~stby_por_n;
   wire por_any  = ~vcc_por_n | stby_por;
   wire hard_any = por_any | ~rst_n;

   reg  [7:0] index_q;
   reg  [7:0] index_address;
   reg  [7:0] logical_device_number;
   reg  [7:0] sysmgmt_irq_enable_2;
   reg  [7:0] sysmgmt_irq_status_1;
   reg  [7:0] sysmgmt_irq_status_2;
   reg  [7:0] pin_multiplex_controls;
   reg  [7:0] force_disk_change;
   reg  [7:0] floppy_rate_shadow;
   reg  [7:0] serial1_fifo_ctl_shadow;
   reg  [7:0] serial2_fifo_ctl_shadow;
   reg  [7:0] power_event_control;
   reg  [7:0] power_event_status;
   reg  [7:0] power_event_wake_status;
   reg  [7:0] power_event_wake_enable;
   reg  [7:0] watchdog_timeout_setting;
   reg  [7:0] watchdog_count_value;
   reg  [7:0] watchdog_setup;
   reg        wdt_flag;
   reg  [1:0] ack_sync;
   reg  [7:0] next_rdata;
   reg        bank_act;

   // Host strobes qualified by configuration mode
   wire idx_wr  = cfg_mode & host_wr & ~host_port; // R03
   wire dat_wr  = cfg_mode & host_wr & host_port; // R03
   wire dat_rd  = cfg_mode & host_rd & host_port; // R03
   wire idx_rd  = cfg_mode & host_rd & ~host_port;
   wire aux_sel = (logical_device_number == `CFGRB_LDN_AUX); // R06
   wire aux_wr  = dat_wr & aux_sel;

   // Write strobe per register, index compared on all eight bits
   wire wr_cfgctl = dat_wr & (index_q == `CFGRB_IX_CFGCTL); // R02
   wire wr_idxadr = dat_wr & (index_q == `CFGRB_IX_IDXADR);
   wire wr_ldn    = dat_wr & (index_q == `CFGRB_IX_LDN);
   wire wr_pwrctl = dat_wr & (index_q == `CFGRB_IX_PWRCTL);
   wire wr_pwrmgt = dat_wr & (index_q == `CFGRB_IX_PWRMGT);
   wire wr_act    = dat_wr & (index_q == `CFGRB_IX_ACT);
   wire wr_smien2 = aux_wr & (index_q == `CFGRB_IX_SMIEN2);
   wire wr_smist1 = aux_wr & (index_q == `CFGRB_IX_SMIST1);
   wire wr_smist2 = aux_wr & (index_q == `CFGRB_IX_SMIST2);
   wire wr_pinmux = aux_wr & (index_q == `CFGRB_IX_PINMUX);
   wire wr_fdchg  = aux_wr & (index_q == `CFGRB_IX_FDCHG);
   wire wr_pmectl = aux_wr & (index_q == `CFGRB_IX_PMECTL);
   wire wr_pmest  = aux_wr & (index_q == `CFGRB_IX_PMEST);
   wire wr_pmewst = aux_wr & (index_q == `CFGRB_IX_PMEWST);
   wire wr_pmewen = aux_wr & (index_q == `CFGRB_IX_PMEWEN);
   wire wr_wdto   = aux_wr & (index_q == `CFGRB_IX_WDTO);
   wire wr_wdval  = aux_wr & (index_q == `CFGRB_IX_WDVAL);
   wire wr_wdset  = aux_wr & (index_q == `CFGRB_IX_WDSET);
   wire wr_wdctl  = aux_wr & (index_q == `CFGRB_IX_WDCTL);

   // Soft reset is the registered pulse, so it lands one cycle after the write
   wire act_clr = hard_any | soft_reset_out;

   // Activate bits live in the banked submodule
   cfgrb_act_bank u_act (
      .sys_clk (sys_clk),
      .clr     (act_clr),
      .wr      (wr_act),
      .ldn     (logical_device_number),
      .wbit    (host_wdata[`CFGRB_ACT_BIT]),
      .act     (activate_out)
   ); // R21

   // Index port and global selector registers
   always @(posedge sys_clk)
   begin
      if (hard_any)
      begin
         index_q               <= `CFGRB_RST_ZERO;
         index_address         <= `CFGRB_RST_IDXADR;
         logical_device_number <= `CFGRB_RST_ZERO;
      end
      else
      begin
         if (idx_wr)
            index_q <= host_wdata; // R02
         if (wr_idxadr)
            index_address <= host_wdata;
         if (wr_ldn)
            logical_device_number <= host_wdata; // R06
      end
   end

   // Soft reset pulse never holds: the bit is gone the cycle after
   always @(posedge sys_clk)
   begin
      if (hard_any)
         soft_reset_out <= 1'b0;
      else
         soft_reset_out <= wr_cfgctl & host_wdata[`CFGRB_SOFT_BIT]; // R04
   end

   // Power control clears on every reset, soft included
   always @(posedge sys_clk)
   begin
      if (hard_any | soft_reset_out)
         power_control_out <= `CFGRB_RST_ZERO; // R11
      else if (wr_pwrctl)
         power_control_out <= host_wdata & `CFGRB_PWR_MASK; // R10
   end

   // Power management ignores soft reset
   always @(posedge sys_clk)
   begin
      if (hard_any)
         power_mgmt_out <= `CFGRB_RST_ZERO; // R13
      else if (wr_pwrmgt)
         power_mgmt_out <= host_wdata & `CFGRB_PWR_MASK; // R12
   end

   // SMI registers: only the power-on resets reach them
   always @(posedge sys_clk)
   begin
      if (por_any)
      begin
         sysmgmt_irq_enable_2 <= `CFGRB_RST_ZERO; // R17
         sysmgmt_irq_status_1 <= `CFGRB_RST_ZERO; // R17
         sysmgmt_irq_status_2 <= `CFGRB_RST_ZERO; // R17
      end
      else
      begin
         if (wr_smien2)
            sysmgmt_irq_enable_2 <= host_wdata;
         // A hardware event in the write cycle is kept
         if (wr_smist1)
            sysmgmt_irq_status_1 <= host_wdata | smi_event_1;
         else
            sysmgmt_irq_status_1 <= sysmgmt_irq_status_1 | smi_event_1;
         if (wr_smist2)
            sysmgmt_irq_status_2 <= host_wdata | smi_event_2;
         else
            sysmgmt_irq_status_2 <= sysmgmt_irq_status_2 | smi_event_2;
      end
   end

   // Pin multiplex and disk change: hard and power-on resets
   always @(posedge sys_clk)
   begin
      if (hard_any)
      begin
         pin_multiplex_controls <= `CFGRB_RST_PINMUX;
         force_disk_change      <= `CFGRB_RST_FDCHG;
      end
      else
      begin
         if (wr_pinmux)
            pin_multiplex_controls <= host_wdata;
         if (wr_fdchg)
            force_disk_change <= host_wdata;
      end
   end

   // Shadows follow the function writes; host writes never reach them
   always @(posedge sys_clk)
   begin
      if (stby_por)
      begin
         floppy_rate_shadow      <= `CFGRB_RST_ZERO;
         serial1_fifo_ctl_shadow <= `CFGRB_RST_ZERO;
         serial2_fifo_ctl_shadow <= `CFGRB_RST_ZERO;
      end
      else
      begin
         if (floppy_rate_wr)
            floppy_rate_shadow <= floppy_rate_data; // R20
         if (serial1_fcr_wr)
            serial1_fifo_ctl_shadow <= serial1_fcr_data; // R20
         if (serial2_fcr_wr)
            serial2_fifo_ctl_shadow <= serial2_fcr_data; // R20
      end
   end

   // PME registers sit on standby power, so only its power-on clears them
   always @(posedge sys_clk)
   begin
      if (stby_por)
      begin
         power_event_control     <= `CFGRB_RST_ZERO; // R19
         power_event_wake_enable <= `CFGRB_RST_ZERO; // R19
         power_event_status      <= `CFGRB_RST_ZERO; // R18
         power_event_wake_status <= `CFGRB_RST_ZERO; // R18
      end
      else
      begin
         if (wr_pmectl)
            power_event_control <= host_wdata;
         if (wr_pmewen)
            power_event_wake_enable <= host_wdata;
         // Write one clears; a new event wins over the clear
         power_event_status <= (power_event_status
                               & ~(wr_pmest ? host_wdata : 8'h00))
                               | pme_event; // R18
         power_event_wake_status <= (power_event_wake_status
                                    & ~(wr_pmewst ? host_wdata : 8'h00))
                                    | wake_event; // R18
      end
   end

   // Watchdog setup registers
   always @(posedge sys_clk)
   begin
      if (hard_any)
      begin
         watchdog_timeout_setting <= `CFGRB_RST_ZERO;
         watchdog_count_value     <= `CFGRB_RST_ZERO;
         watchdog_setup           <= `CFGRB_RST_ZERO;
      end
      else
      begin
         if (wr_wdto)
            watchdog_timeout_setting <= host_wdata;
         if (wr_wdval)
            watchdog_count_value <= host_wdata;
         if (wr_wdset)
            watchdog_setup <= host_wdata;
      end
   end

   // Control bit 0 must outlive a hard reset, so only power-on clears it
   always @(posedge sys_clk)
   begin
      if (por_any)
         wdt_flag <= 1'b0; // R14
      else if (wr_wdctl)
         wdt_flag <= host_wdata[0]; // R15
   end

   // Force bit is write-only: a one-cycle pulse that reads back zero
   always @(posedge sys_clk)
   begin
      if (hard_any)
         wdt_force_out <= 1'b0;
      else
         wdt_force_out <= wr_wdctl & host_wdata[`CFGRB_WDC_FORCE]; // R15
   end

   // Acknowledge pin is asynchronous: two flops before use
   always @(posedge sys_clk)
   begin
      if (por_any)
         ack_sync <= 2'b11;
      else
         ack_sync <= {ack_sync[0], printer_ack_in};
   end

   // Parallel interrupt is parked high while the port is inactive
   always @(posedge sys_clk)
   begin
      if (hard_any)
         parallel_irq_out <= 1'b1;
      else if (!activate_out[`CFGRB_ACT_PAR])
         parallel_irq_out <= 1'b1; // R16
      else
         parallel_irq_out <= ack_sync[1]; // R16
   end

   // Read decode; anything not matched returns zero
   always @*
   begin
      next_rdata = 8'h00; // R01
      if (idx_rd)
         next_rdata = index_q;
      else if (!dat_rd)
         next_rdata = 8'h00;
      else if (index_q == `CFGRB_IX_CFGCTL)
         next_rdata = 8'h00; // R22
      else if (index_q == `CFGRB_IX_IDXADR)
         next_rdata = index_address;
      else if (index_q == `CFGRB_IX_LDN)
         next_rdata = logical_device_number;
      else if (index_q == `CFGRB_IX_DEVID)
         next_rdata = DEVICE_IDENTIFICATION; // R08
      else if (index_q == `CFGRB_IX_DEVREV)
         next_rdata = DEVICE_REV; // R09
      else if (index_q == `CFGRB_IX_PWRCTL)
         next_rdata = power_control_out;
      else if (index_q == `CFGRB_IX_PWRMGT)
         next_rdata = power_mgmt_out; // R12
      else if (index_q < `CFGRB_IX_LDBASE)
         next_rdata = 8'h00; // R01
      else if (index_q == `CFGRB_IX_ACT)
         next_rdata = {7'h00, bank_act}; // R06
      else if (!aux_sel)
         next_rdata = 8'h00;
      else if (index_q == `CFGRB_IX_SMIEN2)
         next_rdata = sysmgmt_irq_enable_2;
      else if (index_q == `CFGRB_IX_SMIST1)
         next_rdata = sysmgmt_irq_status_1;
      else if (index_q == `CFGRB_IX_SMIST2)
         next_rdata = sysmgmt_irq_status_2;
      else if (index_q == `CFGRB_IX_PINMUX)
         next_rdata = pin_multiplex_controls;
      else if (index_q == `CFGRB_IX_FDCHG)
         next_rdata = force_disk_change;
      else if (index_q == `CFGRB_IX_FRATE)
         next_rdata = floppy_rate_shadow; // R20
      else if (index_q == `CFGRB_IX_S1FCR)
         next_rdata = serial1_fifo_ctl_shadow; // R20
      else if (index_q == `CFGRB_IX_S2FCR)
         next_rdata = serial2_fifo_ctl_shadow; // R20
      else if (index_q == `CFGRB_IX_PMECTL)
         next_rdata = power_event_control;
      else if (index_q == `CFGRB_IX_PMEST)
         next_rdata = power_event_status;
      else if (index_q == `CFGRB_IX_PMEWST)
         next_rdata = power_event_wake_status;
      else if (index_q == `CFGRB_IX_PMEWEN)
         next_rdata = power_event_wake_enable;
      else if (index_q == `CFGRB_IX_WDTO)
         next_rdata = watchdog_timeout_setting;
      else if (index_q == `CFGRB_IX_WDVAL)
         next_rdata = watchdog_count_value;
      else if (index_q == `CFGRB_IX_WDSET)
         next_rdata = watchdog_setup;
      else if (index_q == `CFGRB_IX_WDCTL)
         next_rdata = {4'h0, wdt_state, 1'b0, wdt_flag}; // R15
   end

   // Activate bit of the selected bank; unknown device numbers read zero
   always @*
   begin
      bank_act = 1'b0;
      if (logical_device_number == `CFGRB_LDN_FLOPPY)
         bank_act = activate_out[0];
      else if (logical_device_number == `CFGRB_LDN_PAR)
         bank_act = activate_out[1];
      else if (logical_device_number == `CFGRB_LDN_SER1)
         bank_act = activate_out[2];
      else if (logical_device_number == `CFGRB_LDN_SER2)
         bank_act = activate_out[3];
      else if (logical_device_number == `CFGRB_LDN_KBD)
         bank_act = activate_out[4];
      else if (logical_device_number == `CFGRB_LDN_AUX)
         bank_act = activate_out[5];
   end

   // Read data is registered and held until the next read
   always @(posedge sys_clk)
   begin
      if (hard_any)
         host_rdata <= 8'h00;
      else if (idx_rd | dat_rd)
         host_rdata <= next_rdata; // R03
   end

endmodule // cfgrb_top
`default_nettype wire
